// file: verilog/jfpp_port.sv
// JTAG flash programming port: TAP, data registers and flash access sequencing.
// Behaviour
// - Word in page is PC bits 6..0, page index is PC bits 15..7.
// - Port works only with fuse programmed and disable bit clear.
// - External reset low clears a set disable bit after two chip clocks.
// - All shift registers shift least significant bit first.
// - Instruction register is four bits wide.
// - Run-Test/Idle generates internal clocks and serves as idle state.
// - Core reset selects one-bit register; TAP itself is not reset.
// - Reset bit holds core in reset unlatched, then time-out follows.
// - Enable instruction selects 16-bit register compared on Update-DR.
// - Signature is A370 hex; enabled only while register equals it.
// - Enable register clears at power-on; programmer clears it on leaving.
// - Command register 15 bits; Capture loads previous result, Shift exchanges.
// - Update-DR applies command; following Run-Test/Idle executes it once.
// - Page load uses low eight command bits as data byte register.
// - Page load update copies byte then writes page buffer within 11 TCK.
// - Page load alternates low then high byte, starting low.
// - Page load pre-increments PC before each low byte except first.
// - Page read captures alternating bytes, low first, on Capture-DR.
// - Page read post-increments PC after every high byte capture.
`timescale 1ns/1ps
`default_nettype none
module jfpp_port
   import jfpp_pkg::*;
#(
   parameter int RST_TIMEOUT = RST_TIMEOUT_DEF
) (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic nrst_i,
   // JTAG pins.
   input wire logic tck_i,
   input wire logic tms_i,
   input wire logic tdi_i,
   output logic tdo_o,
   output logic tdo_oe_o,
   // Fuse, control bit and external reset.
   input wire logic jtag_port_fuse_i,
   input wire logic jtag_disable_set_i,
   input wire logic ext_reset_n_i,
   output logic jtag_disable_bit_o,
   // Core and programming state.
   output logic core_reset_o,
   output logic prog_mode_o,
   // Flash command path.
   output jfpp_pkg::jfpp_cmd_t cmd_o,
   input wire logic [jfpp_pkg::CMD_W-1:0] cmd_result_i,
   // Program counter loaded by commands.
   input wire logic pc_load_i,
   input wire logic [jfpp_pkg::PC_W-1:0] pc_value_i,
   output logic [jfpp_pkg::PC_W-1:0] pc_o,
   // Page buffer and flash read.
   output jfpp_pkg::jfpp_pbuf_t pbuf_o,
   input wire logic [2*jfpp_pkg::BYTE_W-1:0] flash_word_i
);
   import jfpp_pkg::*;

   initial begin
      if (RST_TIMEOUT < 1) begin
         $error("RST_TIMEOUT must be at least one");
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisation and TCK edge detection.

   logic [3:0] pin_sync;
   logic tck_s, tms_s, tdi_s, extrst_n_s, tck_d;

   jfpp_sync #(.W(4)) u_sync (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .async_i({tck_i, tms_i, tdi_i, ext_reset_n_i}),
      .sync_o(pin_sync)
   );

   assign tck_s = pin_sync[3];
   assign tms_s = pin_sync[2];
   assign tdi_s = pin_sync[1];
   assign extrst_n_s = pin_sync[0];

   wire tck_rise = tck_s & ~tck_d;
   wire tck_fall = ~tck_s & tck_d;

   ////////////////////////////////////////////////////////////////////////////
   // Disable bit and port enable.

   logic [1:0] jtd_cnt;
   wire port_en = jtag_port_fuse_i & ~jtag_disable_bit_o;

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         jtag_disable_bit_o <= 1'b0;
         jtd_cnt <= '0;
      end else if (jtag_disable_set_i) begin
         jtag_disable_bit_o <= 1'b1;
         jtd_cnt <= '0;
      end else if (jtag_disable_bit_o && !extrst_n_s) begin
         if (jtd_cnt == 2'(JTD_CLR_CYCLES - 1)) begin
            jtag_disable_bit_o <= 1'b0;
            jtd_cnt <= '0;
         end else begin
            jtd_cnt <= jtd_cnt + 2'd1;
         end
      end else begin
         jtd_cnt <= '0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // TAP controller, advanced on each sampled TCK rising edge while the port is enabled, held in Test-Logic-Reset otherwise.

   jfpp_tap_t tap, next_tap;

   always_comb begin
      unique case (tap)
         JFPP_TLR: next_tap = tms_s ? JFPP_TLR : JFPP_RTI;
         JFPP_RTI: next_tap = tms_s ? JFPP_SEL_DR : JFPP_RTI;
         JFPP_SEL_DR: next_tap = tms_s ? JFPP_SEL_IR : JFPP_CAP_DR;
         JFPP_CAP_DR: next_tap = tms_s ? JFPP_EX1_DR : JFPP_SHF_DR;
         JFPP_SHF_DR: next_tap = tms_s ? JFPP_EX1_DR : JFPP_SHF_DR;
         JFPP_EX1_DR: next_tap = tms_s ? JFPP_UPD_DR : JFPP_PAU_DR;
         JFPP_PAU_DR: next_tap = tms_s ? JFPP_EX2_DR : JFPP_PAU_DR;
         JFPP_EX2_DR: next_tap = tms_s ? JFPP_UPD_DR : JFPP_SHF_DR;
         JFPP_UPD_DR: next_tap = tms_s ? JFPP_SEL_DR : JFPP_RTI;
         JFPP_SEL_IR: next_tap = tms_s ? JFPP_TLR : JFPP_CAP_IR;
         JFPP_CAP_IR: next_tap = tms_s ? JFPP_EX1_IR : JFPP_SHF_IR;
         JFPP_SHF_IR: next_tap = tms_s ? JFPP_EX1_IR : JFPP_SHF_IR;
         JFPP_EX1_IR: next_tap = tms_s ? JFPP_UPD_IR : JFPP_PAU_IR;
         JFPP_PAU_IR: next_tap = tms_s ? JFPP_EX2_IR : JFPP_PAU_IR;
         JFPP_EX2_IR: next_tap = tms_s ? JFPP_UPD_IR : JFPP_SHF_IR;
         JFPP_UPD_IR: next_tap = tms_s ? JFPP_SEL_DR : JFPP_RTI;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         tck_d <= 1'b0;
         tap <= JFPP_TLR;
      end else begin
         tck_d <= tck_s;
         if (!port_en) begin
            tap <= JFPP_TLR;
         end else if (tck_rise) begin
            tap <= next_tap;
         end
      end
   end

   wire step = port_en & tck_rise;
   wire in_cap_dr = step & (tap == JFPP_CAP_DR);
   wire in_shf_dr = step & (tap == JFPP_SHF_DR);
   wire in_upd_dr = step & (tap == JFPP_UPD_DR);
   wire in_rti = step & (tap == JFPP_RTI);

   ////////////////////////////////////////////////////////////////////////////
   // Instruction register and decode.

   logic [IR_W-1:0] ir, ir_shift;

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         ir <= IR_RESET_VAL;
         ir_shift <= '0;
      end else if (tap == JFPP_TLR) begin
         ir <= IR_RESET_VAL;
      end else if (step) begin
         unique case (tap)
            JFPP_CAP_IR: ir_shift <= 4'h1;
            JFPP_SHF_IR: ir_shift <= {tdi_s, ir_shift[IR_W-1:1]};
            JFPP_UPD_IR: ir <= ir_shift;
            default: ir <= ir;
         endcase
      end
   end

   wire sel_rst = (ir == CORE_RESET_INSTR);
   wire sel_pen = (ir == PROGRAMMING_ENABLE_INSTR);
   wire sel_cmd = (ir == PROGRAMMING_COMMAND_INSTR);
   wire sel_pld = (ir == PAGE_LOAD_INSTR);
   wire sel_prd = (ir == PAGE_READ_INSTR);
   wire ir_upd = step & (tap == JFPP_UPD_IR);

   ////////////////////////////////////////////////////////////////////////////
   // Reset, enable and command data registers.

   logic rst_bit;
   logic [PEN_W-1:0] pen_shift, pen_reg;
   logic [CMD_W-1:0] cmd_shift;
   logic cmd_pending;

   // The reset bit feeds the core reset register without an Update-DR latch, so reset lags it by one chip clock.
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         rst_bit <= 1'b0;
         pen_shift <= '0;
         pen_reg <= PEN_RESET_VAL;
      end else begin
         if (in_shf_dr && sel_rst) begin
            rst_bit <= tdi_s;
         end
         if (in_shf_dr && sel_pen) begin
            pen_shift <= {tdi_s, pen_shift[PEN_W-1:1]};
         end
         if (in_upd_dr && sel_pen) begin
            pen_reg <= pen_shift;
         end
      end
   end

   wire prog_en = (pen_reg == PEN_SIGNATURE);

   ////////////////////////////////////////////////////////////////////////////
   // Page load and read sequencing.

   logic byte_high;
   logic first_byte;
   logic [BYTE_W-1:0] tmp_byte;
   logic [1:0] pld_cnt;
   logic pld_busy;
   wire [PC_W-1:0] pc_inc = pc_o + 16'h0001;

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         cmd_shift <= '0;
         cmd_pending <= 1'b0;
         cmd_o <= '0;
         pc_o <= '0;
         byte_high <= 1'b0;
         first_byte <= 1'b1;
         tmp_byte <= '0;
         pld_cnt <= '0;
         pld_busy <= 1'b0;
         pbuf_o <= '0;
      end else begin
         cmd_o.apply <= 1'b0;
         cmd_o.exec <= 1'b0;
         pbuf_o.we <= 1'b0;
         if (ir_upd) begin
            byte_high <= 1'b0;
            first_byte <= 1'b1;
         end
         if (pc_load_i) begin
            pc_o <= pc_value_i;
         end
         if (in_cap_dr && sel_cmd) begin
            cmd_shift <= cmd_result_i;
         end else if (in_cap_dr && sel_prd && prog_en) begin
            cmd_shift[BYTE_W-1:0] <= byte_high ? flash_word_i[2*BYTE_W-1:BYTE_W]
                                               : flash_word_i[BYTE_W-1:0];
            byte_high <= ~byte_high;
            if (byte_high) begin
               pc_o <= pc_inc;
            end
         end else if (in_shf_dr && sel_cmd) begin
            cmd_shift <= {tdi_s, cmd_shift[CMD_W-1:1]};
         end else if (in_shf_dr && (sel_pld || sel_prd)) begin
            cmd_shift[BYTE_W-1:0] <= {tdi_s, cmd_shift[BYTE_W-1:1]};
         end
         if (in_upd_dr && sel_cmd && prog_en) begin
            cmd_o.cmd <= cmd_shift;
            cmd_o.apply <= 1'b1;
            cmd_pending <= 1'b1;
         end else if (in_rti && cmd_pending) begin
            cmd_o.exec <= 1'b1;
            cmd_pending <= 1'b0;
         end
         if (in_upd_dr && sel_pld && prog_en) begin
            tmp_byte <= cmd_shift[BYTE_W-1:0];
            pld_busy <= 1'b1;
            pld_cnt <= '0;
         end else if (pld_busy) begin
            if (pld_cnt == 2'(PLOAD_DELAY - 1)) begin
               pld_busy <= 1'b0;
               pbuf_o.we <= 1'b1;
               pbuf_o.high <= byte_high;
               pbuf_o.data <= tmp_byte;
               byte_high <= ~byte_high;
               first_byte <= 1'b0;
               if (!byte_high && !first_byte) begin
                  pc_o <= pc_inc;
                  pbuf_o.addr <= pc_inc;
               end else begin
                  pbuf_o.addr <= pc_o;
               end
            end else begin
               pld_cnt <= pld_cnt + 2'd1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Reset time-out, TDO and mode outputs.

   logic [$clog2(RST_TIMEOUT+1)-1:0] rst_tmo;

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         rst_tmo <= '0;
         core_reset_o <= 1'b0;
         prog_mode_o <= 1'b0;
         tdo_o <= 1'b0;
         tdo_oe_o <= 1'b0;
      end else begin
         if (rst_bit) begin
            rst_tmo <= ($clog2(RST_TIMEOUT+1))'(RST_TIMEOUT);
         end else if (rst_tmo != '0) begin
            rst_tmo <= rst_tmo - 1'b1;
         end
         core_reset_o <= rst_bit | (rst_tmo != '0);
         prog_mode_o <= prog_en;
         if (tck_fall) begin
            tdo_oe_o <= port_en & ((tap == JFPP_SHF_DR) | (tap == JFPP_SHF_IR));
            if (tap == JFPP_SHF_IR) begin
               tdo_o <= ir_shift[0];
            end else if (sel_rst) begin
               tdo_o <= rst_bit;
            end else if (sel_pen) begin
               tdo_o <= pen_shift[0];
            end else begin
               tdo_o <= cmd_shift[0];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions.

   AST_SIG_MATCH: assert property (@(posedge clk_i) disable iff (!nrst_i)
      prog_mode_o == $past(pen_reg == PEN_SIGNATURE))
      else $error("programming mode does not follow signature match");

   AST_JTD_CLR: assert property (@(posedge clk_i) disable iff (!nrst_i)
      jtag_disable_bit_o && !extrst_n_s && !jtag_disable_set_i ##1
      !extrst_n_s && !jtag_disable_set_i |=> !jtag_disable_bit_o)
      else $error("disable bit not cleared after two clocks");

   AST_RST_IMM: assert property (@(posedge clk_i) disable iff (!nrst_i)
      rst_bit |=> core_reset_o)
      else $error("core reset not asserted while reset bit set");

   AST_RST_HOLD: assert property (@(posedge clk_i) disable iff (!nrst_i)
      $fell(rst_bit) |-> core_reset_o [*2])
      else $error("core reset released without time-out");

   sequence s_cmd_update;
      in_upd_dr && sel_cmd && prog_en;
   endsequence

   AST_CMD_APPLY: assert property (@(posedge clk_i) disable iff (!nrst_i)
      s_cmd_update |=> cmd_o.apply && cmd_o.cmd == $past(cmd_shift))
      else $error("command not applied on update");

   AST_PLD_WRITE: assert property (@(posedge clk_i) disable iff (!nrst_i)
      in_upd_dr && sel_pld && prog_en |-> ##[1:4] pbuf_o.we)
      else $error("page buffer write late");

   AST_PRD_INC: assert property (@(posedge clk_i) disable iff (!nrst_i)
      in_cap_dr && sel_prd && prog_en && byte_high && !pc_load_i |=> pc_o == $past(pc_inc))
      else $error("read did not advance program counter");

   AST_PORT_OFF: assert property (@(posedge clk_i) disable iff (!nrst_i)
      !port_en |=> tap == JFPP_TLR)
      else $error("TAP active while port disabled");

   AST_PLD_FIRST: assert property (@(posedge clk_i) disable iff (!nrst_i)
      pbuf_o.we && $past(first_byte) |-> !pbuf_o.high && pbuf_o.addr == $past(pc_o))
      else $error("first page-load byte misplaced");

endmodule
`default_nettype wire

// file: verilog/jfpp_pkg.sv
// Package of constants and types for the JTAG flash programming port.
package jfpp_pkg;

   // Flash page geometry.
   localparam int PC_W = 16;
   localparam int WORD_LSB = 0;
   localparam int WORD_MSB = 6;
   localparam int PAGE_LSB = 7;
   localparam int PAGE_MSB = 15;

   // TAP and data register widths.
   localparam int IR_W = 4;
   localparam int PEN_W = 16;
   localparam int CMD_W = 15;
   localparam int BYTE_W = 8;

   // Instruction opcodes.
   localparam logic [3:0] CORE_RESET_INSTR = 4'hC;
   localparam logic [3:0] PROGRAMMING_ENABLE_INSTR = 4'h4;
   localparam logic [3:0] PROGRAMMING_COMMAND_INSTR = 4'h5;
   localparam logic [3:0] PAGE_LOAD_INSTR = 4'h6;
   localparam logic [3:0] PAGE_READ_INSTR = 4'h7;
   localparam logic [3:0] IR_RESET_VAL = 4'hF;

   // Programming enable signature and reset values.
   localparam logic [15:0] PEN_SIGNATURE = 16'hA370;
   localparam logic [15:0] PEN_RESET_VAL = 16'h0000;

   // Chip clocks before the disable bit is cleared under external reset.
   localparam int JTD_CLR_CYCLES = 2;
   // Page buffer write is issued a fixed number of chip clocks after update; well inside 11 TCK.
   localparam int PLOAD_TCK_LIMIT = 11;
   localparam int PLOAD_DELAY = 2;
   // Default reset time-out in chip clocks.
   localparam int RST_TIMEOUT_DEF = 64;

   // TAP controller states, Gray-coded along the DR path.
   typedef enum logic [3:0] {
      JFPP_TLR = 4'h0,
      JFPP_RTI = 4'h1,
      JFPP_SEL_DR = 4'h3,
      JFPP_CAP_DR = 4'h2,
      JFPP_SHF_DR = 4'h6,
      JFPP_EX1_DR = 4'h7,
      JFPP_PAU_DR = 4'h5,
      JFPP_EX2_DR = 4'h4,
      JFPP_UPD_DR = 4'hC,
      JFPP_SEL_IR = 4'hD,
      JFPP_CAP_IR = 4'hF,
      JFPP_SHF_IR = 4'hE,
      JFPP_EX1_IR = 4'hA,
      JFPP_PAU_IR = 4'hB,
      JFPP_EX2_IR = 4'h9,
      JFPP_UPD_IR = 4'h8
   } jfpp_tap_t;

   // Command strobe travelling to the flash controller.
   typedef struct packed {
      logic apply;
      logic exec;
      logic [CMD_W-1:0] cmd;
   } jfpp_cmd_t;

   // Page buffer write request.
   typedef struct packed {
      logic we;
      logic high;
      logic [PC_W-1:0] addr;
      logic [BYTE_W-1:0] data;
   } jfpp_pbuf_t;

endpackage

// file: verilog/jfpp_sync.sv
// Two-flip-flop synchroniser for a group of pin inputs.
`timescale 1ns/1ps
`default_nettype none
module jfpp_sync #(
   parameter int W = 4
) (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic nrst_i,
   // Asynchronous inputs and their synchronised copies.
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o
);
   logic [W-1:0] meta;

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         meta <= '0;
         sync_o <= '0;
      end else begin
         meta <= async_i;
         sync_o <= meta;
      end
   end
endmodule
`default_nettype wire

// file: dv/jfpp_jtag_model.sv
// Behavioural model of the external JTAG programmer that drives the port.
`timescale 1ns/1ps
`default_nettype none
module jfpp_jtag_model (
   // Chip clock, used only to pace the link.
   input wire logic clk_i,
   // JTAG pins.
   input wire logic tdo_i,
   output logic tck_o,
   output logic tms_o,
   output logic tdi_o
);
   initial begin
      tck_o = 1'b1;
      tms_o = 1'b1;
      tdi_o = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // One TCK period is eight chip clocks, since the port cannot divide TCK down.
   task automatic step(input logic tms, input logic tdi, output logic tdo);
      @(negedge clk_i);
      tck_o = 1'b0;
      tms_o = tms;
      tdi_o = tdi;
      repeat (4) @(negedge clk_i);
      tdo = tdo_i;
      tck_o = 1'b1;
      repeat (3) @(negedge clk_i);
   endtask

   task automatic idle(input int n);
      logic t;
      repeat (n) step(1'b0, tdi_o, t);
   endtask

   task automatic reset_tap();
      logic t;
      repeat (5) step(1'b1, tdi_o, t);
      step(1'b0, tdi_o, t);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Full scan from Run-Test/Idle back to Run-Test/Idle.
   task automatic scan(input logic is_ir, input int n, input logic [31:0] din, output logic [31:0] dout);
      logic t;
      int i;
      dout = '0;
      step(1'b1, tdi_o, t);
      if (is_ir) begin
         step(1'b1, tdi_o, t);
      end
      step(1'b0, tdi_o, t);
      step(1'b0, tdi_o, t);
      for (i = 0; i < n; i++) begin
         step(i == n - 1, din[i], t);
         dout[i] = t;
      end
      step(1'b1, tdi_o, t);
      step(1'b0, tdi_o, t);
      // A released data line must not keep showing the last bit.
      tdi_o = ~tdi_o;
   endtask
endmodule
`default_nettype wire

// file: dv/jfpp_port_tb.sv
// Self-checking testbench for the JTAG flash programming port.
`timescale 1ns/1ps
`default_nettype none
module jfpp_port_tb;
   import jfpp_pkg::*;
   logic clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic tck;
   logic tms;
   logic tdi;
   logic tdo;
   logic tdo_oe;
   logic fuse = 1'b1;
   logic dis_set = 1'b0;
   logic ext_rst_n = 1'b1;
   logic dis_bit;
   logic core_rst;
   logic prog_mode;
   jfpp_cmd_t cmd;
   logic [CMD_W-1:0] cmd_res = 15'h1234;
   logic pc_load = 1'b0;
   logic [PC_W-1:0] pc_val = 16'h0000;
   logic [PC_W-1:0] pc;
   jfpp_pbuf_t pbuf;
   logic [15:0] flash_word;
   int bad_count = 0;
   int compares = 0;
   int cycles = 0;
   int n_apply = 0;
   int n_exec = 0;
   int n_oe = 0;
   jfpp_pbuf_t writes[$];
   logic [31:0] dout;

   always #50 clk_i = ~clk_i;

   // Flash stand-in: the word at pc carries its own low address byte.
   assign flash_word = {pc[7:0] ^ 8'hA5, pc[7:0]};

   jfpp_port #(.RST_TIMEOUT(4)) dut (
      .clk_i(clk_i), .nrst_i(nrst_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo), .tdo_oe_o(tdo_oe),
      .jtag_port_fuse_i(fuse), .jtag_disable_set_i(dis_set), .ext_reset_n_i(ext_rst_n),
      .jtag_disable_bit_o(dis_bit), .core_reset_o(core_rst), .prog_mode_o(prog_mode), .cmd_o(cmd),
      .cmd_result_i(cmd_res), .pc_load_i(pc_load), .pc_value_i(pc_val), .pc_o(pc), .pbuf_o(pbuf),
      .flash_word_i(flash_word)
   );

   jfpp_jtag_model model (.clk_i(clk_i), .tdo_i(tdo), .tck_o(tck), .tms_o(tms), .tdi_o(tdi));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      if (bad_count == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Pulses are counted one edge late, which is harmless for counting.
   always @(posedge clk_i) begin
      cycles++;
      if (cmd.apply === 1'b1) n_apply++;
      if (cmd.exec === 1'b1) n_exec++;
      if (tdo_oe === 1'b1) n_oe++;
      if (pbuf.we === 1'b1) writes.push_back(pbuf);
      if (cycles == 30000) begin
         bad_count++;
         report_and_stop();
      end
   end

   task automatic ir(input logic [3:0] code);
      model.scan(1'b1, IR_W, {28'h000_0000, code}, dout);
   endtask

   task automatic dr(input int n, input logic [31:0] val);
      model.scan(1'b0, n, val, dout);
      // Registered outputs lag the last TCK edge by the synchroniser; let them settle.
      repeat (4) @(negedge clk_i);
   endtask

   task automatic load_pc(input logic [15:0] v);
      @(negedge clk_i);
      pc_val = v;
      pc_load = 1'b1;
      @(negedge clk_i);
      pc_load = 1'b0;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      check(32'(core_rst), 32'h0000_0000);
      check(32'(prog_mode), 32'h0000_0000);
      check(32'(dis_bit), 32'h0000_0000);
   endtask

   task automatic t_gate();
      fuse = 1'b0;
      model.reset_tap();
      ir(CORE_RESET_INSTR);
      dr(1, 32'h0000_0001);
      check(32'(core_rst), 32'h0000_0000);
      fuse = 1'b1;
      dis_set = 1'b1;
      @(negedge clk_i);
      dis_set = 1'b0;
      check(32'(dis_bit), 32'h0000_0001);
      model.reset_tap();
      ir(CORE_RESET_INSTR);
      dr(1, 32'h0000_0001);
      check(32'(core_rst), 32'h0000_0000);
      ext_rst_n = 1'b0;
      repeat (8) @(negedge clk_i);
      check(32'(dis_bit), 32'h0000_0000);
      ext_rst_n = 1'b1;
      repeat (4) @(negedge clk_i);
   endtask

   task automatic t_core();
      model.reset_tap();
      ir(CORE_RESET_INSTR);
      dr(1, 32'h0000_0001);
      check(32'(core_rst), 32'h0000_0001);
      // No fresh instruction here: a TAP reset would lose the selection.
      dr(1, 32'h0000_0000);
      repeat (8) @(negedge clk_i);
      check(32'(core_rst), 32'h0000_0000);
   endtask

   task automatic t_enable();
      int a;
      ir(CORE_RESET_INSTR);
      dr(1, 32'h0000_0001);
      ir(PROGRAMMING_ENABLE_INSTR);
      dr(PEN_W, {16'h0000, PEN_SIGNATURE ^ 16'h0001});
      check(32'(prog_mode), 32'h0000_0000);
      a = n_apply;
      ir(PROGRAMMING_COMMAND_INSTR);
      dr(CMD_W, 32'h0000_2A5B);
      check(n_apply, a);
      ir(PROGRAMMING_ENABLE_INSTR);
      dr(PEN_W, {16'h0000, PEN_SIGNATURE});
      check(32'(prog_mode), 32'h0000_0001);
   endtask

   task automatic t_cmd();
      int a;
      int e;
      int o;
      a = n_apply;
      e = n_exec;
      ir(PROGRAMMING_COMMAND_INSTR);
      o = n_oe;
      dr(CMD_W, 32'h0000_2A5B);
      check(dout, 32'h0000_1234);
      check(n_oe, o + CMD_W * 8);
      check(32'(cmd.cmd), 32'h0000_2A5B);
      check(n_apply, a + 1);
      check(n_exec, e);
      // The execute clock comes from the first TCK cycle spent in Run-Test/Idle.
      model.idle(1);
      repeat (4) @(negedge clk_i);
      check(n_exec, e + 1);
      model.idle(2);
      repeat (4) @(negedge clk_i);
      check(n_exec, e + 1);
   endtask

   task automatic t_load();
      int k;
      load_pc(16'h017E);
      ir(PAGE_LOAD_INSTR);
      writes.delete();
      for (k = 0; k < 4; k++) begin
         dr(BYTE_W, 32'h0000_00C0 + k);
         check(writes.size(), k + 1);
      end
      for (k = 0; k < 4; k++) begin
         check(32'(writes[k].addr), 32'h0000_017E + k / 2);
         check(32'(writes[k].high), k % 2);
         check(32'(writes[k].data), 32'h0000_00C0 + k);
      end
      check(32'(pc), 32'h0000_017F);
   endtask

   task automatic t_read();
      load_pc(16'h017F);
      ir(PAGE_READ_INSTR);
      dr(BYTE_W, 32'h0000_0000);
      check(dout, 32'h0000_007F);
      dr(BYTE_W, 32'h0000_0000);
      check(dout, 32'h0000_00DA);
      check(32'(pc), 32'h0000_0180);
      check(32'(pc[15:7]), 32'h0000_0003);
   endtask

   task automatic t_leave();
      ir(PROGRAMMING_ENABLE_INSTR);
      dr(PEN_W, 32'h0000_0000);
      check(32'(prog_mode), 32'h0000_0000);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (10) @(negedge clk_i);
      nrst_i = 1'b1;
      repeat (4) @(negedge clk_i);
      t_reset();
      t_gate();
      t_core();
      t_enable();
      t_cmd();
      t_load();
      t_read();
      t_leave();
      report_and_stop();
   end
endmodule
`default_nettype wire
